/* rtl/sacc_pkg.sv */
// Shared constants and types for the conversion control block.
package sacc_pkg;
  localparam int RES_BITS = 16;
  localparam int CLK_PERIOD_NS = 10;
  // Minimum acquisition time after a conversion.
  localparam int ACQ_TIME_NS = 1800;
  // Time given to each successive-approximation bit trial.
  localparam int BIT_TIME_NS = 400;
  localparam logic [15:0] ACQ_CYCLES =
    16'((ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] BIT_CYCLES =
    16'((BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] LAST_BIT = 4'h0;
  localparam logic [3:0] FIRST_BIT = 4'hF;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Synchroniser bit positions.
  localparam int SY_CNV = 0;
  localparam int SY_CS = 1;
  localparam int SY_RD = 2;
  localparam int SY_RST = 3;
  localparam int SY_PD = 4;
  localparam int SY_SCLK = 5;
  localparam int SY_REFDIS = 6;
  localparam int SY_BUFDIS = 7;
  localparam int SY_CODE = 8;
  localparam int SY_W = 9;
  // Idle levels: active-low strobes high, reset asserted, references off.
  localparam logic [8:0] SY_RST_VAL = 9'h0CF;

  typedef enum logic [2:0] {
    ST_ACQ = 3'h0,
    ST_WAIT = 3'h1,
    ST_CONV = 3'h3,
    ST_LOAD = 3'h2,
    ST_PWRDN = 3'h6
  } sacc_state_t;

  typedef struct packed {
    sacc_state_t state;
    logic [15:0] cnt;
    logic [3:0] bit_idx;
    logic [15:0] trial;
    logic [15:0] result;
    logic [15:0] shift;
    logic cnv_prev;
    logic sclk_prev;
  } sacc_regs_t;
endpackage : sacc_pkg

/* rtl/sacc_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/100ps
module sacc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule : sacc_sync

/* rtl/sacc_ctrl.sv */
// Conversion sequencer and host-facing control of a 16-bit SAR converter.
//
// Summary of operation
// - Busy rises at conversion start, falls after result enters the shift register.
// - Output bus is enabled only while chip select and read are both low.
// - Chip select gates the external serial clock; inactive select ignores it.
// - Reset pin high returns to reset state, aborting any conversion.
// - Power-down lets a running conversion finish, then blocks new starts.
// - Start high at end of acquisition: wait for falling edge, then convert.
// - Start already low at end of acquisition: hold and convert at once.
// - Internal reference on while its disable is low, off while high.
// - Reference buffer on while its disable is low, off while high.
// - Result coded straight binary or twos complement per coding select.
`timescale 1ns/100ps
module sacc_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_convert_start_n,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_reset,
  input wire logic i_power_down_req,
  input wire logic i_internal_ref_disable,
  input wire logic i_ref_buffer_disable,
  input wire logic i_coding_select,
  input wire logic i_ext_sclk,
  input wire logic i_comp_keep,
  output logic o_busy,
  output logic o_hold,
  output logic [sacc_pkg::RES_BITS-1:0] o_dac_code,
  output logic [sacc_pkg::RES_BITS-1:0] o_data,
  output logic o_data_oe,
  output logic o_sdout,
  output logic o_sdout_oe,
  output logic o_ref_enable,
  output logic o_buf_enable,
  output logic o_low_power
);
  import sacc_pkg::*;

  logic [SY_W-1:0] pins_s;
  sacc_regs_t cur_ff;
  sacc_regs_t nxt_regs;
  logic start_fall;
  logic sclk_rise;
  logic bus_en;

  sacc_sync #(
    .W(SY_W),
    .RST_VAL(SY_RST_VAL)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async({i_coding_select, i_ref_buffer_disable, i_internal_ref_disable,
              i_ext_sclk, i_power_down_req, i_reset, i_rd_n, i_cs_n,
              i_convert_start_n}),
    .o_sync(pins_s)
  );

  assign start_fall = cur_ff.cnv_prev & ~pins_s[SY_CNV];
  // The serial clock only counts while chip select is active.
  assign sclk_rise = ~cur_ff.sclk_prev & pins_s[SY_SCLK] & ~pins_s[SY_CS];

  always_comb begin
    logic [15:0] decided;
    decided = cur_ff.trial;
    nxt_regs = cur_ff;
    nxt_regs.cnv_prev = pins_s[SY_CNV];
    nxt_regs.sclk_prev = pins_s[SY_SCLK];
    if (sclk_rise) begin
      nxt_regs.shift = {cur_ff.shift[14:0], 1'b0};
    end
    unique case (cur_ff.state)
      ST_ACQ: begin
        // Starts seen during acquisition are not taken; the sampling phase must run out.
        if (cur_ff.cnt >= ACQ_CYCLES - 16'h0001) begin
          nxt_regs.cnt = 16'h0000;
          if (pins_s[SY_PD]) begin
            nxt_regs.state = ST_PWRDN;
          end else if (!pins_s[SY_CNV]) begin
            nxt_regs.state = ST_CONV;
            nxt_regs.bit_idx = FIRST_BIT;
            nxt_regs.trial = 16'h8000;
          end else begin
            nxt_regs.state = ST_WAIT;
          end
        end else begin
          nxt_regs.cnt = cur_ff.cnt + 16'h0001;
        end
      end
      ST_WAIT: begin
        if (pins_s[SY_PD]) begin
          nxt_regs.state = ST_PWRDN;
        end else if (start_fall) begin
          nxt_regs.state = ST_CONV;
          nxt_regs.cnt = 16'h0000;
          nxt_regs.bit_idx = FIRST_BIT;
          nxt_regs.trial = 16'h8000;
        end
      end
      ST_CONV: begin
        // Power-down is not looked at here, so a running conversion completes.
        if (cur_ff.cnt >= BIT_CYCLES - 16'h0001) begin
          nxt_regs.cnt = 16'h0000;
          if (!i_comp_keep) begin
            decided[cur_ff.bit_idx] = 1'b0;
          end
          if (cur_ff.bit_idx == LAST_BIT) begin
            nxt_regs.trial = decided;
            nxt_regs.state = ST_LOAD;
          end else begin
            decided[cur_ff.bit_idx - 4'h1] = 1'b1;
            nxt_regs.trial = decided;
            nxt_regs.bit_idx = cur_ff.bit_idx - 4'h1;
          end
        end else begin
          nxt_regs.cnt = cur_ff.cnt + 16'h0001;
        end
      end
      ST_LOAD: begin
        // Coding high gives straight binary; low flips the sign bit for twos complement.
        nxt_regs.result = {cur_ff.trial[15] ^ ~pins_s[SY_CODE], cur_ff.trial[14:0]};
        nxt_regs.shift = {cur_ff.trial[15] ^ ~pins_s[SY_CODE], cur_ff.trial[14:0]};
        nxt_regs.state = ST_ACQ;
        nxt_regs.cnt = 16'h0000;
      end
      ST_PWRDN: begin
        if (!pins_s[SY_PD]) begin
          nxt_regs.state = ST_ACQ;
          nxt_regs.cnt = 16'h0000;
        end
      end
      default: begin
        nxt_regs.state = ST_ACQ;
        nxt_regs.cnt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || pins_s[SY_RST]) begin
      cur_ff <= '{state: ST_ACQ, cnt: 16'h0000, bit_idx: FIRST_BIT, trial: RST_WORD,
                  result: RST_WORD, shift: RST_WORD, cnv_prev: 1'b1, sclk_prev: 1'b0};
    end else begin
      cur_ff <= nxt_regs;
    end
  end

  // Busy covers the bit trials and the load cycle, so its fall means fresh data.
  assign o_busy = (cur_ff.state == ST_CONV) || (cur_ff.state == ST_LOAD);
  assign o_hold = (cur_ff.state == ST_CONV);
  assign o_dac_code = cur_ff.trial;
  assign o_data = cur_ff.result;
  assign o_sdout = cur_ff.shift[15];
  assign bus_en = ~pins_s[SY_CS] & ~pins_s[SY_RD];
  assign o_data_oe = bus_en;
  assign o_sdout_oe = bus_en;
  assign o_ref_enable = ~pins_s[SY_REFDIS];
  assign o_buf_enable = ~pins_s[SY_BUFDIS];
  assign o_low_power = (cur_ff.state == ST_PWRDN);
endmodule : sacc_ctrl

/* verif/sacc_props.sv */
// Port checker for the conversion control block.
`timescale 1ns/100ps
module sacc_props (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_reset,
  input wire logic i_convert_start_n,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_internal_ref_disable,
  input wire logic i_power_down_req,
  input wire logic o_busy,
  input wire logic o_hold,
  input wire logic o_data_oe,
  input wire logic o_ref_enable,
  input wire logic o_low_power
);
  import sacc_pkg::*;

  // Busy spans every bit trial plus the load cycle.
  localparam logic [15:0] CONV_LEN = 16'(RES_BITS) * BIT_CYCLES + 16'h0001;
  logic [15:0] busy_len_ff;
  logic [2:0] rst_seen_ff;

  // The busy run is counted here, since a delay that long is too costly to unroll.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !o_busy) begin
      busy_len_ff <= 16'h0000;
    end else begin
      busy_len_ff <= busy_len_ff + 16'h0001;
    end
    // The pin reset reaches the sequencer through a synchroniser, so its effect lags.
    rst_seen_ff <= {rst_seen_ff[1:0], i_reset};
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  property p_hold; o_hold |-> o_busy; endproperty
  a_hold: assert property (p_hold) else $error("hold without busy");
  // A pin reset cuts a conversion short, so it must disable this length check too.
  property p_len; disable iff (!i_rst_n || i_reset || (|rst_seen_ff))
    $fell(o_busy) |-> (busy_len_ff == CONV_LEN) && !$past(o_hold); endproperty
  a_len: assert property (p_len) else $error("busy length");
  property p_len_max; o_busy |-> busy_len_ff < CONV_LEN; endproperty
  a_len_max: assert property (p_len_max) else $error("busy too long");
  property p_oe; o_data_oe |-> !$past(i_cs_n, 2) && !$past(i_rd_n, 2); endproperty
  a_oe: assert property (p_oe) else $error("bus enabled");
  property p_ref; o_ref_enable |-> !$past(i_internal_ref_disable, 2); endproperty
  a_ref: assert property (p_ref) else $error("reference on");
  property p_rst; i_reset [*3] |=> !o_busy && !o_hold; endproperty
  a_rst: assert property (p_rst) else $error("no abort");
  property p_pd; o_low_power |-> !o_busy; endproperty
  a_pd: assert property (p_pd) else $error("busy in power down");
  property p_pd_entry;
    $rose(o_low_power) |-> $past(i_power_down_req, 3) && !$past(o_busy);
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power down entry");
  property p_start; $rose(o_busy) |-> !$past(i_convert_start_n, 3); endproperty
  a_start: assert property (p_start) else $error("start cause");
  property p_gap; $rose(o_busy) |-> !$past(o_busy, 180); endproperty
  a_gap: assert property (p_gap) else $error("start too soon");
  c_conv: cover property ($fell(o_busy));
  c_pd: cover property ($rose(o_low_power));
  c_oe: cover property ($rose(o_data_oe));
endmodule : sacc_props
bind sacc_ctrl sacc_props u_props (
  .i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n),
  .i_reset(i_reset),
  .i_convert_start_n(i_convert_start_n),
  .i_cs_n(i_cs_n),
  .i_rd_n(i_rd_n),
  .i_internal_ref_disable(i_internal_ref_disable),
  .i_power_down_req(i_power_down_req),
  .o_busy(o_busy),
  .o_hold(o_hold),
  .o_data_oe(o_data_oe),
  .o_ref_enable(o_ref_enable),
  .o_low_power(o_low_power)
);

/* verif/sacc_host.sv */
// Host reader and comparator model at the far side.
`timescale 1ns/100ps
module sacc_host (
  input wire logic i_clk_sys,
  input wire logic [15:0] i_dac,
  input wire logic i_sdout,
  input wire logic i_oe,
  output logic o_cs_n = 1'h1,
  output logic o_rd_n = 1'h1,
  output logic o_sclk = 1'h0,
  output logic o_keep = 1'h0
);
  logic [15:0] vin = 16'h0000;
  always @(negedge i_clk_sys) o_keep <= i_dac <= vin;
  task automatic wt(int n);
    repeat (n) @(negedge i_clk_sys);
  endtask : wt
  // Two clock pulses go out unselected first; they must not shift the word.
  task automatic rd(output logic [15:0] w);
    for (int i = 0; i < 18; i++) begin
      o_cs_n = i < 2;
      o_rd_n = i < 2;
      wt(4);
      w = {w[14:0], i_oe ? i_sdout : 1'hX};
      o_sclk = 1'h1;
      wt(4);
      o_sclk = 1'h0;
    end
    o_cs_n = 1'h1;
    o_rd_n = 1'h1;
  endtask : rd
endmodule : sacc_host

/* verif/sacc_ctrl_tb_top.sv */
// Self-checking bench for the conversion control block.
`timescale 1ns/100ps
module sacc_ctrl_tb_top;
  logic clk = 0, rst_n = 0, cnv_n = 1, rpin = 1, pd = 0, refd = 0, bufd = 0, code = 0;
  logic cs_n, rd_n, sclk, keep, busy, sdo, oe, ref_en, buf_en, lowp;
  logic [15:0] dac, dat, w;
  logic [31:0] lfsr = 32'hA309AF9A;
  int fail_count = 0, cmp_count = 0, cyc = 0, n;
  always #5 clk = ~clk;
  sacc_ctrl uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_convert_start_n(cnv_n),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .i_reset(rpin), .i_power_down_req(pd),
    .i_internal_ref_disable(refd), .i_ref_buffer_disable(bufd), .i_coding_select(code),
    .i_ext_sclk(sclk), .i_comp_keep(keep), .o_busy(busy), .o_hold(), .o_dac_code(dac),
    .o_data(dat), .o_data_oe(), .o_sdout(sdo), .o_sdout_oe(oe), .o_ref_enable(ref_en),
    .o_buf_enable(buf_en), .o_low_power(lowp));
  sacc_host host (.i_clk_sys(clk), .i_dac(dac), .i_sdout(sdo), .i_oe(oe),
    .o_cs_n(cs_n), .o_rd_n(rd_n), .o_sclk(sclk), .o_keep(keep));
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [15:0] coded(logic [15:0] v, logic c);
    return c ? v : v ^ 16'h8000;
  endfunction : coded
  task automatic give_verdict;
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wt(int k);
    repeat (k) @(negedge clk);
  endtask : wt
  task automatic wbusy;
    n = 0;
    while (busy !== 1'h1 && n < 400) begin
      wt(1);
      n++;
    end
    chk("busy_rise", 1, busy);
  endtask : wbusy
  task automatic conv(logic imm, logic dopd, logic [15:0] v);
    lfsr = lfsr_next(lfsr);
    host.vin = v;
    {code, refd, bufd} = lfsr[2:0];
    cnv_n = !imm;
    if (!imm) begin
      wt(200);
      cnv_n = 0;
    end
    wbusy();
    pd = dopd;
    cnv_n = 1;
    wt(5);
    cnv_n = 0;
    wt(5);
    cnv_n = 1;
    chk("ref_en", !refd, ref_en);
    chk("buf_en", !bufd, buf_en);
    wt(630);
    chk("busy_hi", 1, busy);
    wt(1);
    chk("busy_lo", 0, busy);
    chk("data", coded(v, code), dat);
    host.rd(w);
    chk("serial", coded(v, code), w);
    if (dopd) begin
      wt(200);
      chk("low_power", 1, lowp);
      cnv_n = 0;
      wt(20);
      chk("busy_pd", 0, busy);
      pd = 0;
    end
  endtask : conv
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    wt(16);
    rst_n = 1;
    wt(2);
    rpin = 0;
    conv(0, 0, 16'hFFFF);
    conv(1, 0, 16'h0000);
    for (int i = 0; i < 4; i++) conv(lfsr[3], i == 3, lfsr[31:16]);
    wbusy();
    wt(100);
    rpin = 1;
    wt(3);
    rpin = 0;
    chk("abort", 0, busy);
    cnv_n = 1;
    conv(0, 0, 16'h8000);
    give_verdict();
  end
endmodule : sacc_ctrl_tb_top
